// file: logic/dcf_pkg.sv
// Shared constants, carriers and pointer helpers for the dual clock FIFO
package dcf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int DATA_W    = 18;
    localparam int DEPTH_DEF = 32768;
    localparam int DEPTH_MIN = 2048;
    localparam int DEPTH_MAX = 65536;
    localparam int OFF_W     = 16;
    localparam int GPTR_W    = 17;
    localparam int SYNC_N    = 2;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [OFF_W-1:0]  OFF_DEF_PAR = 16'h007F;
    localparam logic [OFF_W-1:0]  OFF_DEF_SER = 16'h03FF;
    localparam logic [DATA_W-1:0] DATA_RST    = 18'h00000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [OFF_W-1:0] full;
        logic [OFF_W-1:0] empty;
    } dcf_offsets_t;

    typedef struct packed {
        logic fall_through_mode;
        logic serial;
    } dcf_mode_t;

    // ------------------------------------------------------------------
    // Gray helpers, used zero-extended to the widest pointer
    // ------------------------------------------------------------------
    function automatic logic [GPTR_W-1:0] dcf_bin2gray(
        input logic [GPTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [GPTR_W-1:0] dcf_gray2bin(
        input logic [GPTR_W-1:0] g);
        logic [GPTR_W-1:0] b;
        b = '0;
        b[GPTR_W-1] = g[GPTR_W-1];
        for (int i = GPTR_W - 2; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction

endpackage

// file: logic/dcf_fifo.sv
// Dual clock 18-bit FIFO with standard and fall-through timing
//
// Contract
// (R01) Write stores data_in, advances write pointer
// (R02) Read moves next word to data_out
// (R03) data_out driven only while output enabled
// (R04) Write and read clocks fully asynchronous
// (R05) Standard mode: first word needs explicit read
// (R06) Fall-through: first word appears without read
// (R07) Fall-through: later words need read enable
// (R08) Timing mode latched during master reset
// (R09) Fall-through stages chain with no glue
// (R10) Mode picks empty/full or ready flags
// (R11) Almost flags use independent offset registers
// (R12) Load pin picks 127 parallel, 1023 serial
// (R13) Serial load shifts one offset bit
// (R14) Parallel load takes offsets from data_in
// (R15) Offset read presents offsets on data_out
// (R16) Master reset clears pointers, sets defaults
// (R17) Partial reset clears pointers, keeps settings
// (R18) Retransmit rewinds read pointer to zero
// (R19) Idle power-down when no control active
// (R20) Depth 32768 or 65536 words of 18; code takes any power of two from 2048 to 65536
// (R21) Almost-full when count exceeds capacity minus offset
// (R22) Almost-empty when count below empty offset
// (R23) Half-full shows more than half capacity
// (R24) Retransmit briefly shows empty, keeps write side
// (R25) Writes when full, reads when empty ignored
//
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
)
(
    // Write side
    input  wire logic              write_clock,
    input  wire logic              write_enable_n,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              serial_load_enable_n,
    input  wire logic              mode_select_serial_in,
    // Read side
    input  wire logic              read_clock,
    input  wire logic              read_enable_n,
    input  wire logic              output_enable_n,
    input  wire logic              retransmit_n,
    // Shared control pins
    input  wire logic              offset_load_n,
    input  wire logic              master_reset_n,
    input  wire logic              partial_reset_n,
    // Data out, three-state as data plus enable
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_out_en,
    // Flags
    output logic                   empty_flag_n,
    output logic                   full_flag_n,
    output logic                   output_ready,
    output logic                   input_ready,
    output logic                   half_full_flag_n,
    output logic                   almost_empty_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   power_down
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [GPTR_W-1:0] CAP  = GPTR_W'(DEPTH);
    localparam logic [GPTR_W-1:0] HALF = GPTR_W'(DEPTH / 2);

    // Only power-of-two depths keep the gray pointers one-bit-change
    if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (1 << AW) != DEPTH)
    begin : g_depth_bad
        $error("dcf_fifo: DEPTH must be a power of two, 2048..65536");
    end

    logic [DATA_W-1:0] mem [DEPTH];  // R20

    // ------------------------------------------------------------------
    // Write domain
    // ------------------------------------------------------------------
    logic [SYNC_N-1:0] wr_mrs_q;
    logic [SYNC_N-1:0] wr_prs_q;
    logic              wr_mrs;
    logic              wr_prs;
    logic              wr_rst;
    dcf_mode_t         mode;
    dcf_offsets_t      offs;
    logic              par_sel;
    logic              off_tgl;
    logic [1:0]        off_quiet;
    logic              ld_ser;
    logic              ld_par;
    logic [PW-1:0]     wbin;
    logic [PW-1:0]     wgray;
    logic [PW-1:0]     rgray;
    logic [PW-1:0]     rg_s1;
    logic [PW-1:0]     rg_s2;
    logic [PW-1:0]     rbin_w;
    logic              wr_full;
    logic              wr_take;
    logic [PW-1:0]     next_wbin;
    logic [GPTR_W-1:0] wr_cnt;
    logic              wr_idle;

    // Reset pins are asynchronous to both clocks
    always_ff @(posedge write_clock)
    begin
        wr_mrs_q <= {wr_mrs_q[0], ~master_reset_n};
        wr_prs_q <= {wr_prs_q[0], ~partial_reset_n};
    end

    assign wr_mrs = wr_mrs_q[SYNC_N-1];
    assign wr_prs = wr_prs_q[SYNC_N-1];
    assign wr_rst = wr_mrs | wr_prs;

    // Straps caught while master reset is held
    always_ff @(posedge write_clock)
    begin
        if (wr_mrs)
        begin
            mode.fall_through_mode   <= mode_select_serial_in;  // R08
            mode.serial <= offset_load_n;          // R12
        end
    end

    assign ld_ser = mode.serial & ~serial_load_enable_n & ~offset_load_n
                    & ~wr_rst;
    assign ld_par = ~mode.serial & ~write_enable_n & ~offset_load_n
                    & ~wr_rst;

    // Offsets survive partial reset untouched
    always_ff @(posedge write_clock)
    begin
        if (wr_mrs)
        begin
            offs.full  <= offset_load_n ? OFF_DEF_SER : OFF_DEF_PAR;  // R12
            offs.empty <= offset_load_n ? OFF_DEF_SER : OFF_DEF_PAR;
        end
        else if (ld_ser)
            offs <= {offs[2*OFF_W-2:0], mode_select_serial_in};  // R13
        else if (ld_par)
        begin
            if (par_sel)
                offs.full <= data_in[OFF_W-1:0];  // R14
            else
                offs.empty <= data_in[OFF_W-1:0];  // R11
        end
    end

    always_ff @(posedge write_clock)
    begin
        if (wr_rst)
            par_sel <= 1'b0;
        else if (ld_par)
            par_sel <= ~par_sel;
    end

    // One toggle per burst of changes, sent once the settings are quiet;
    // a load within a few read edges after the toggle starts a new burst and gets its own toggle
    always_ff @(posedge write_clock)
    begin
        if (wr_mrs | ld_ser | ld_par)
            off_quiet <= 2'h3;
        else if (off_quiet != 2'h0)
            off_quiet <= off_quiet - 2'h1;
    end

    // Forced to a known level in master reset so it never stays unknown
    always_ff @(posedge write_clock)
    begin
        if (wr_mrs)
            off_tgl <= 1'b1;
        else if (off_quiet == 2'h1)
            off_tgl <= ~off_tgl;
    end

    // Read pointer crossing in gray code
    always_ff @(posedge write_clock)
    begin
        rg_s1 <= rgray;  // R04
        rg_s2 <= rg_s1;
    end

    assign rbin_w    = PW'(dcf_gray2bin(GPTR_W'(rg_s2)));
    assign wr_full   = (wbin ^ rbin_w) == {1'b1, {AW{1'b0}}};
    assign wr_take   = ~write_enable_n & offset_load_n & ~wr_full  // R25
                       & ~wr_rst;
    assign next_wbin = wbin + PW'(wr_take);
    assign wr_cnt    = GPTR_W'(PW'(next_wbin - rbin_w));

    always_ff @(posedge write_clock)
    begin
        if (wr_rst)
        begin
            wbin  <= '0;  // R16 R17
            wgray <= '0;
        end
        else
        begin
            wbin  <= next_wbin;  // R01
            wgray <= PW'(dcf_bin2gray(GPTR_W'(next_wbin)));
        end
    end

    always_ff @(posedge write_clock)
    begin
        if (wr_take)
            mem[wbin[AW-1:0]] <= data_in;  // R01
    end

    // Flags reflect the state after this edge
    always_ff @(posedge write_clock)
    begin
        if (wr_mrs)
        begin
            full_flag_n        <= 1'b1;
            input_ready        <= 1'b1;
            half_full_flag_n   <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end
        else
        begin
            full_flag_n        <= mode.fall_through_mode | (wr_cnt != CAP);  // R10
            input_ready        <= ~mode.fall_through_mode | (wr_cnt == CAP);  // R09
            half_full_flag_n   <= ~(wr_cnt > HALF);  // R23
            almost_full_flag_n <=
                ~(wr_cnt > CAP - GPTR_W'(offs.full));  // R21
        end
    end

    always_ff @(posedge write_clock)
    begin
        wr_idle <= write_enable_n & serial_load_enable_n;  // R19
    end

    // ------------------------------------------------------------------
    // Read domain
    // ------------------------------------------------------------------
    logic [SYNC_N-1:0] rd_mrs_q;
    logic [SYNC_N-1:0] rd_prs_q;
    logic              rd_mrs;
    logic              rd_prs;
    logic              rd_rst;
    logic [2:0]        tgl_q;
    dcf_mode_t         mode_r;
    dcf_offsets_t      offs_r;
    logic [PW-1:0]     wg_s1;
    logic [PW-1:0]     wg_s2;
    logic [PW-1:0]     wbin_r;
    logic [PW-1:0]     rbin;
    logic [PW-1:0]     next_rbin;
    logic              rd_empty;
    logic              rd_rt;
    logic              rd_ren;
    logic              rd_ofs;
    logic              rd_fetch;
    logic              rd_sel;
    logic              out_valid;
    logic              next_valid;
    logic [GPTR_W-1:0] rd_cnt;
    logic [SYNC_N-1:0] idle_q;

    always_ff @(posedge read_clock)
    begin
        rd_mrs_q <= {rd_mrs_q[0], ~master_reset_n};
        rd_prs_q <= {rd_prs_q[0], ~partial_reset_n};
        idle_q   <= {idle_q[0], wr_idle};
    end

    assign rd_mrs = rd_mrs_q[SYNC_N-1];
    assign rd_prs = rd_prs_q[SYNC_N-1];
    assign rd_rst = rd_mrs | rd_prs;

    // Settings are held steady around each toggle, so a wide copy is safe;
    // loads closer than the sync delay are caught by the last toggle
    always_ff @(posedge read_clock)
    begin
        tgl_q <= {tgl_q[1:0], off_tgl};
        if (rd_mrs | (tgl_q[2] ^ tgl_q[1]))
        begin
            mode_r <= mode;
            offs_r <= offs;
        end
    end

    always_ff @(posedge read_clock)
    begin
        wg_s1 <= wgray;  // R04
        wg_s2 <= wg_s1;
    end

    assign wbin_r   = PW'(dcf_gray2bin(GPTR_W'(wg_s2)));
    assign rd_empty = rbin == wbin_r;
    assign rd_rt    = ~retransmit_n;
    assign rd_ren   = ~read_enable_n & offset_load_n;
    assign rd_ofs   = ~read_enable_n & ~offset_load_n;

    // Fall-through refills an empty output stage by itself
    assign rd_fetch = ~rd_rt & ~rd_empty & ~rd_ofs & ~rd_rst  // R25
                      & (mode_r.fall_through_mode ? (~out_valid | rd_ren)  // R06 R07
                                     : rd_ren);               // R05 R02
    assign next_rbin = rd_rt ? '0 : rbin + PW'(rd_fetch);  // R18
    assign rd_cnt    = GPTR_W'(PW'(wbin_r - next_rbin));

    always_comb
    begin
        next_valid = out_valid;
        if (rd_rst | rd_rt | ~mode_r.fall_through_mode)
            next_valid = 1'b0;  // R24
        else if (rd_fetch)
            next_valid = 1'b1;
        else if (rd_ren)
            next_valid = 1'b0;
    end

    always_ff @(posedge read_clock)
    begin
        if (rd_rst)
        begin
            rbin  <= '0;  // R16 R17
            rgray <= '0;
        end
        else
        begin
            rbin  <= next_rbin;
            rgray <= PW'(dcf_bin2gray(GPTR_W'(next_rbin)));
        end
    end

    always_ff @(posedge read_clock)
    begin
        out_valid <= next_valid;
    end

    // Memory is only read on a fetch, keeping the array quiet when idle
    always_ff @(posedge read_clock)
    begin
        if (rd_rst)
            data_out <= DATA_RST;
        else if (rd_ofs)
            data_out <= DATA_W'(rd_sel ? offs_r.full : offs_r.empty);  // R15
        else if (rd_fetch)
            data_out <= mem[rbin[AW-1:0]];  // R02 R19
    end

    always_ff @(posedge read_clock)
    begin
        if (rd_rst)
            rd_sel <= 1'b0;
        else if (rd_ofs)
            rd_sel <= ~rd_sel;
    end

    always_ff @(posedge read_clock)
    begin
        if (rd_mrs)
        begin
            empty_flag_n        <= 1'b0;
            output_ready        <= 1'b1;
            almost_empty_flag_n <= 1'b0;
        end
        else
        begin
            empty_flag_n <= mode_r.fall_through_mode  // R10
                            | ~(rd_rt | rd_rst | next_rbin == wbin_r);
            output_ready <= ~next_valid;  // R09
            almost_empty_flag_n <=
                ~(rd_cnt < GPTR_W'(offs_r.empty));  // R22
        end
    end

    always_ff @(posedge read_clock)
    begin
        data_out_en <= ~output_enable_n;  // R03
        power_down  <= read_enable_n & retransmit_n  // R19
                       & offset_load_n & idle_q[SYNC_N-1];
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_fall_idle;
        mode_r.fall_through_mode && !out_valid && !rd_empty && !rd_rt && !rd_ofs;
    endsequence

    sequence s_rewind;
        !retransmit_n;
    endsequence

    property p_write_adv;
        @(posedge write_clock) disable iff (wr_rst)
        wr_take |=> wbin == PW'($past(wbin) + PW'(1));
    endproperty
    a_write_adv: assert property (p_write_adv)  // R01
        else $error("write pointer did not advance");

    property p_full_hold;
        @(posedge write_clock) disable iff (wr_rst)
        wr_full && !write_enable_n |=> $stable(wbin);
    endproperty
    a_full_hold: assert property (p_full_hold)  // R25
        else $error("write accepted while full");

    property p_master;
        @(posedge write_clock)
        wr_mrs |=> wbin == '0 && mode.fall_through_mode == $past(mode_select_serial_in);
    endproperty
    a_master: assert property (p_master)  // R16
        else $error("master reset did not clear or latch mode");

    property p_default_par;
        @(posedge write_clock)
        wr_mrs && !offset_load_n |=>
            offs.empty == OFF_DEF_PAR && offs.full == OFF_DEF_PAR;
    endproperty
    a_default_par: assert property (p_default_par)  // R12
        else $error("parallel default offsets wrong");

    property p_partial;
        @(posedge write_clock)
        wr_prs && !wr_mrs |=> wbin == '0 && $stable(mode) && $stable(offs);
    endproperty
    a_partial: assert property (p_partial)  // R17
        else $error("partial reset lost settings");

    property p_par_load;
        @(posedge write_clock) disable iff (wr_rst)
        ld_par |=> par_sel != $past(par_sel);
    endproperty
    a_par_load: assert property (p_par_load)  // R14
        else $error("parallel offset load did not step");

    property p_oe;
        @(posedge read_clock)
        output_enable_n |=> !data_out_en;
    endproperty
    a_oe: assert property (p_oe)  // R03
        else $error("data driven while output disabled");

    property p_std_hold;
        @(posedge read_clock) disable iff (rd_rst)
        !mode_r.fall_through_mode && read_enable_n && retransmit_n
            |=> $stable(data_out) && $stable(rbin);
    endproperty
    a_std_hold: assert property (p_std_hold)  // R05
        else $error("standard mode output moved without read");

    property p_fall_first;
        @(posedge read_clock) disable iff (rd_rst)
        s_fall_idle |=> out_valid && !output_ready;
    endproperty
    a_fall_first: assert property (p_fall_first)  // R06
        else $error("first word did not fall through");

    property p_fall_hold;
        @(posedge read_clock) disable iff (rd_rst)
        mode_r.fall_through_mode && out_valid && read_enable_n && retransmit_n
            |=> out_valid && $stable(data_out);
    endproperty
    a_fall_hold: assert property (p_fall_hold)  // R07
        else $error("fall-through word changed without read");

    property p_rewind;
        @(posedge read_clock) disable iff (rd_rst)
        s_rewind |=> rbin == '0
            && (mode_r.fall_through_mode ? output_ready : !empty_flag_n);
    endproperty
    a_rewind: assert property (p_rewind)  // R18 R24
        else $error("retransmit did not rewind");

endmodule

// file: tb/dcf_producer.sv
// Upstream producer model for the write port of the dual clock FIFO
module dcf_producer
    import dcf_pkg::*;
(
    // Clock
    input  wire logic              write_clock,
    // Command from the bench
    input  wire logic              start,
    input  wire logic [15:0]       count,
    input  wire logic [DATA_W-1:0] base,
    // Write port
    output logic                   write_enable_n = 1'b1,
    output logic      [DATA_W-1:0] data_in = 18'h00000
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0]       left = 16'h0000;
    logic [DATA_W-1:0] nxt  = 18'h00000;

    // ------------------------------------------------------------------
    // Word stream
    // ------------------------------------------------------------------
    // One word per edge, back to back; offsets ride the same port
    // Idle bus toggles, so a stale word is never mistaken for a write
    always @(posedge write_clock)
        if (start)
        begin
            left <= count;
            nxt  <= base;
        end
        else if (left != 16'h0000)
        begin
            write_enable_n <= 1'b0;
            data_in        <= nxt;
            nxt            <= nxt + 18'h00001;
            left           <= left - 16'h0001;
        end
        else
        begin
            write_enable_n <= 1'b1;
            data_in        <= ~data_in;
        end
endmodule

// file: tb/dcf_fifo_tb.sv
// Self-checking bench for the dual clock FIFO
module dcf_fifo_tb
    import dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DEPTH = 2048;
    logic              write_clock = 1'b0;
    logic              read_clock = 1'b0;
    logic              serial_load_enable_n = 1'b1;
    logic              mode_select_serial_in = 1'b0;
    logic              read_enable_n = 1'b1;
    logic              output_enable_n = 1'b0;
    logic              retransmit_n = 1'b1;
    logic              offset_load_n = 1'b1;
    logic              master_reset_n = 1'b0;
    logic              partial_reset_n = 1'b1;
    logic              start = 1'b0;
    logic [15:0]       count = 16'h0000;
    logic [DATA_W-1:0] base = 18'h00000;
    logic [DATA_W-1:0] nv = 18'h00020;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] data_in, data_out;
    logic              write_enable_n, data_out_en, empty_flag_n;
    logic              full_flag_n, output_ready, input_ready;
    logic              half_full_flag_n, almost_empty_flag_n;
    logic              almost_full_flag_n, power_down;
    logic [31:0]       sv = 32'h00120034;
    int                n_errors = 0;
    int                compares = 0;
    int                cycles = 0;

    // ------------------------------------------------------------------
    // Clocks, unrelated in phase and rate
    // ------------------------------------------------------------------
    initial forever #12.5 write_clock = ~write_clock;
    initial forever #17.5 read_clock = ~read_clock;

    dcf_fifo #(.DEPTH(DEPTH)) u_dcf_fifo (
        .write_clock, .write_enable_n, .data_in, .serial_load_enable_n,
        .mode_select_serial_in, .read_clock, .read_enable_n,
        .output_enable_n, .retransmit_n, .offset_load_n, .master_reset_n,
        .partial_reset_n, .data_out, .data_out_en, .empty_flag_n,
        .full_flag_n, .output_ready, .input_ready, .half_full_flag_n,
        .almost_empty_flag_n, .almost_full_flag_n, .power_down);

    dcf_producer u_dcf_producer (
        .write_clock, .start, .count, .base, .write_enable_n, .data_in);

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [DATA_W-1:0] got,
                            input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic settle;
        repeat (8) @(posedge read_clock);
        @(negedge read_clock);
    endtask

    // Producer needs two edges to start, then one word per edge
    task automatic wr(input int n, input logic [DATA_W-1:0] b);
        @(posedge write_clock);
        start <= 1'b1;
        count <= 16'(n);
        base  <= b;
        @(posedge write_clock);
        start <= 1'b0;
        repeat (n + 2) @(posedge write_clock);
    endtask

    task automatic fill(input int n);
        wr(n, nv);
        nv = nv + DATA_W'(n);
        settle();
    endtask

    task automatic rd(input logic off, output logic [DATA_W-1:0] q);
        @(posedge read_clock);
        read_enable_n <= 1'b0;
        offset_load_n <= ~off;
        @(posedge read_clock);
        read_enable_n <= 1'b1;
        offset_load_n <= 1'b1;
        @(negedge read_clock);
        q = data_out;
    endtask

    task automatic chk_off(input logic [DATA_W-1:0] e,
                           input logic [DATA_W-1:0] f);
        logic [DATA_W-1:0] q;
        rd(1'b1, q);
        chk_word(q, e);
        rd(1'b1, q);
        chk_word(q, f);
    endtask

    // Straps held steady through the whole reset
    task automatic mrst(input logic mode, input logic ld);
        @(posedge read_clock);
        mode_select_serial_in <= mode;
        offset_load_n         <= ld;
        master_reset_n        <= 1'b0;
        repeat (6) @(posedge read_clock);
        master_reset_n <= 1'b1;
        repeat (2) @(posedge read_clock);
        offset_load_n         <= 1'b1;
        mode_select_serial_in <= 1'b0;
        settle();
    endtask

    // Pointers back to the first location, settings kept
    task automatic prst;
        @(posedge read_clock);
        partial_reset_n <= 1'b0;
        repeat (6) @(posedge read_clock);
        partial_reset_n <= 1'b1;
        settle();
    endtask

    // ------------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------------
    always @(posedge write_clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        mrst(1'b0, 1'b0);
        chk_flag(empty_flag_n, 1'b0);
        chk_flag(full_flag_n, 1'b1);
        chk_flag(almost_empty_flag_n, 1'b0);
        chk_flag(power_down, 1'b1);
        chk_off(18'h0007F, 18'h0007F);
        $display("defaults test done");

        wr(3, 18'h00010);
        settle();
        chk_word(data_out, 18'h0007F);
        chk_flag(empty_flag_n, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            rd(1'b0, v);
            chk_word(v, 18'h00010 + DATA_W'(i));
        end
        rd(1'b0, v);
        chk_word(v, 18'h00012);
        @(posedge read_clock);
        output_enable_n <= 1'b1;
        repeat (2) @(posedge read_clock);
        chk_flag(data_out_en, 1'b0);
        output_enable_n <= 1'b0;
        repeat (2) @(posedge read_clock);
        chk_flag(data_out_en, 1'b1);
        $display("standard test done");

        @(posedge write_clock);
        offset_load_n <= 1'b0;
        wr(2, 18'h00005);
        offset_load_n <= 1'b1;
        settle();
        chk_off(18'h00005, 18'h00006);
        fill(4);
        chk_flag(almost_empty_flag_n, 1'b0);
        fill(1);
        chk_flag(almost_empty_flag_n, 1'b1);
        fill(1019);
        chk_flag(half_full_flag_n, 1'b1);
        fill(1);
        chk_flag(half_full_flag_n, 1'b0);
        fill(1017);
        chk_flag(almost_full_flag_n, 1'b1);
        fill(1);
        chk_flag(almost_full_flag_n, 1'b0);
        fill(5);
        chk_flag(full_flag_n, 1'b0);
        wr(2, 18'h3FFF0);
        settle();
        for (int i = 0; i < DEPTH; i++)
        begin
            rd(1'b0, v);
            chk_word(v, 18'h00020 + DATA_W'(i));
        end
        settle();
        chk_flag(empty_flag_n, 1'b0);
        $display("flags test done");

        prst();
        wr(4, 18'h00100);
        settle();
        rd(1'b0, v);
        rd(1'b0, v);
        @(posedge read_clock);
        retransmit_n <= 1'b0;
        @(posedge read_clock);
        retransmit_n <= 1'b1;
        settle();
        wr(1, 18'h00104);
        settle();
        for (int i = 0; i < 5; i++)
        begin
            rd(1'b0, v);
            chk_word(v, 18'h00100 + DATA_W'(i));
        end
        prst();
        chk_flag(empty_flag_n, 1'b0);
        chk_off(18'h00005, 18'h00006);
        $display("retransmit test done");

        mrst(1'b1, 1'b1);
        chk_off(18'h003FF, 18'h003FF);
        chk_flag(output_ready, 1'b1);
        chk_flag(input_ready, 1'b0);
        wr(1, 18'h00200);
        settle();
        chk_flag(output_ready, 1'b0);
        chk_word(data_out, 18'h00200);
        wr(1, 18'h00201);
        settle();
        chk_word(data_out, 18'h00200);
        rd(1'b0, v);
        chk_word(v, 18'h00201);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge write_clock);
            serial_load_enable_n  <= 1'b0;
            offset_load_n         <= 1'b0;
            mode_select_serial_in <= sv[i];
        end
        @(posedge write_clock);
        serial_load_enable_n <= 1'b1;
        offset_load_n        <= 1'b1;
        settle();
        chk_off(18'h00034, 18'h00012);
        $display("fall-through test done");
        conclude();
    end
endmodule
